/* src/mcc_top.sv */
// Calibration bank: registers, power correction, current detection and checksum check
//
// Implementation choice: register access over Avalon-MM.
`default_nettype none
module mcc_top
	import mcc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire mcc_avm_req_t avm_req_i,
	output logic [31:0] avm_readdata_o,
	output logic avm_waitrequest_o,
	input wire logic [31:0] ext_cfg_i [MCC_NEXT],
	input wire logic line_rst_i,
	input wire mcc_power_t raw_power_i,
	input wire logic raw_valid_i,
	input wire logic signed [31:0] cur_sample_i,
	input wire logic cur_valid_i,
	output mcc_power_t cal_power_o,
	output logic cal_valid_o,
	output logic [31:0] bandpass_coef_o,
	output logic cur_present_o,
	output logic config_checksum_ok_o,
	output logic irq_o
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Apply gain fraction and offset to one power word
	// The full 64-bit product keeps every bit before the 31-bit shift drops the fraction
	// The result wraps at 32 bits, like the downstream power words do
	function automatic logic signed [31:0] mcc_cal(input logic signed [31:0] p,
		input logic signed [31:0] s, input logic signed [31:0] c);
		logic signed [63:0] prod;
		logic signed [32:0] sum;
		prod = 64'(p) * 64'(s); // RQ1
		sum = 33'(p) + 33'(prod >>> MCC_FRAC_BITS) + 33'(c); // RQ2
		mcc_cal = sum[31:0];
	endfunction

	// Merge a write word under byte enables
	// Calibration words honour all four lanes; control words use lane 0 only
	function automatic logic [31:0] mcc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		mcc_merge = r;
	endfunction

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	localparam logic [9:0] CAL_IDX [MCC_NCAL] = '{MCC_IDX_BANDPASS, MCC_IDX_FA_GAIN,
		MCC_IDX_FA_OFFS, MCC_IDX_FR_GAIN, MCC_IDX_FR_OFFS, MCC_IDX_TA_GAIN, MCC_IDX_TA_OFFS,
		MCC_IDX_TR_GAIN, MCC_IDX_TR_OFFS, MCC_IDX_CONFIG_CHECKSUM, MCC_IDX_THRESH};

	// Bank storage; the datapath relies on the index order of the table above
	logic [31:0] cal_q [MCC_NCAL];
	logic [1:0] ctrl_q;
	logic [MCC_NEV-1:0] stat_q;
	logic [MCC_NEV-1:0] mask_q;
	logic [MCC_NEV-1:0] ev;
	// Reset sources and bus take strobes
	logic swrst_q;
	logic line_s1_q;
	logic line_s2_q;
	logic soft_clr;
	logic wr_take;
	logic rd_take;
	logic rd_pend_q;

	// Single-wait-state slave: a request is taken on the cycle after it is seen
	// Waiting one cycle lets the read word be registered without a long path to the pins
	assign wr_take = avm_req_i.write & rd_pend_q;
	assign rd_take = avm_req_i.read & rd_pend_q;

	// Line reset comes from the receive pin, so synchronise it first
	// Only the second stage feeds logic, so a metastable first stage never spreads
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			line_s1_q <= 1'b0;
			line_s2_q <= 1'b0;
		end else begin
			line_s1_q <= line_rst_i;
			line_s2_q <= line_s1_q;
		end
	end

	assign soft_clr = line_s2_q | swrst_q; // RQ9

	// Calibration words, cleared by every reset source
	// Zero is the default of every word, the bandpass coefficient included
	generate
		for (genvar g = 0; g < MCC_NCAL; g++) begin : g_cal
			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					cal_q[g] <= MCC_RST_WORD; // RQ9 RQ6
				end else if (soft_clr) begin
					cal_q[g] <= MCC_RST_WORD; // RQ9
				end else if (wr_take && avm_req_i.address == CAL_IDX[g]) begin
					cal_q[g] <= mcc_merge(cal_q[g], avm_req_i.writedata, avm_req_i.byteenable);
				end
			end
		end
	endgenerate

	// Control word; the reset bit self-clears after one cycle
	// Writing bit 1 resets the bank one cycle later, and the bit always reads back zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= 2'h0;
			swrst_q <= 1'b0;
		end else begin
			swrst_q <= wr_take && avm_req_i.address == MCC_IDX_CTRL && avm_req_i.byteenable[0]
				&& avm_req_i.writedata[MCC_CTRL_SWRST];
			if (swrst_q) begin
				ctrl_q <= 2'h0;
			end else if (wr_take && avm_req_i.address == MCC_IDX_CTRL && avm_req_i.byteenable[0]) begin
				ctrl_q <= {1'b0, avm_req_i.writedata[MCC_CTRL_DET_EN]};
			end
		end
	end

	// ---------------------------------------------------------------
	// Power correction
	// ---------------------------------------------------------------
	// Corrected words update only on a strobe, so they hold between samples
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cal_power_o <= '0;
			cal_valid_o <= 1'b0;
		end else begin
			cal_valid_o <= raw_valid_i;
			if (raw_valid_i) begin
				cal_power_o.total_active <= mcc_cal(raw_power_i.total_active, cal_q[5], cal_q[6]); // RQ3
				cal_power_o.total_reactive <= mcc_cal(raw_power_i.total_reactive, cal_q[7], cal_q[8]); // RQ3
				cal_power_o.fund_active <= mcc_cal(raw_power_i.fund_active, cal_q[1], cal_q[2]); // RQ3
				cal_power_o.fund_reactive <= mcc_cal(raw_power_i.fund_reactive, cal_q[3], cal_q[4]); // RQ3
			end
		end
	end

	// ---------------------------------------------------------------
	// Current detection
	// ---------------------------------------------------------------
	logic [3:0] run_q;
	logic [32:0] cur_mag;
	logic above;

	// Magnitude is 33 bits so the most negative sample does not wrap
	// Threshold is signed, so a negative value makes every sample count as above
	assign cur_mag = cur_sample_i[31] ? 33'(-34'(cur_sample_i)) : 33'(cur_sample_i); // RQ4
	assign above = $signed({1'b0, cur_mag}) > 34'(signed'(cal_q[10])); // RQ4

	// Count consecutive samples above threshold; a quiet sample restarts the run
	// The count stops at the run length, so present stays high while samples stay above
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_q <= 4'h0;
			cur_present_o <= 1'b0;
		end else if (!ctrl_q[MCC_CTRL_DET_EN] || soft_clr) begin
			run_q <= 4'h0;
			cur_present_o <= 1'b0;
		end else if (cur_valid_i) begin
			if (!above) begin
				run_q <= 4'h0; // RQ5
				cur_present_o <= 1'b0;
			end else if (run_q != MCC_DET_RUN) begin
				run_q <= run_q + 4'h1; // RQ5
				cur_present_o <= (run_q + 4'h1) == MCC_DET_RUN; // RQ5
			end
		end
	end

	// ---------------------------------------------------------------
	// Checksum over 24 covered words plus the checksum word
	// ---------------------------------------------------------------
	logic [31:0] ck_sum;
	logic ck_ok;

	// Covered set: ten bank words, 14 outside words and the checksum word itself
	// The sum is combinational, so a change anywhere shows on the next edge
	always_comb begin
		ck_sum = 32'h0;
		for (int i = 0; i < MCC_NCAL; i++) begin
			ck_sum = ck_sum + cal_q[i]; // RQ7
		end
		for (int i = 0; i < MCC_NEXT; i++) begin
			ck_sum = ck_sum + ext_cfg_i[i]; // RQ7
		end
	end
	assign ck_ok = ck_sum == MCC_CONFIG_CHECKSUM_GOOD; // RQ7 RQ8

	// Registered so the status output never glitches while the adder settles

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			config_checksum_ok_o <= 1'b0;
		end else begin
			config_checksum_ok_o <= ck_ok; // RQ10
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status, mask and output
	// ---------------------------------------------------------------
	logic pres_d_q;

	// Delayed copy turns the present level into a one-cycle event

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pres_d_q <= 1'b0;
		end else begin
			pres_d_q <= cur_present_o;
		end
	end

	assign ev[MCC_EV_CKERR] = !ck_ok; // RQ10
	assign ev[MCC_EV_DET] = cur_present_o & ~pres_d_q;

	// Set beats the write-one clear so an event in the clearing cycle stays
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_q <= '0;
			mask_q <= '0;
		end else begin
			if (wr_take && avm_req_i.address == MCC_IDX_IRQ_STAT && avm_req_i.byteenable[0]) begin
				stat_q <= (stat_q & ~avm_req_i.writedata[MCC_NEV-1:0]) | ev; // RQ10
			end else begin
				stat_q <= stat_q | ev; // RQ10
			end
			if (wr_take && avm_req_i.address == MCC_IDX_IRQ_MASK && avm_req_i.byteenable[0]) begin
				mask_q <= avm_req_i.writedata[MCC_NEV-1:0];
			end
		end
	end

	// Level interrupt, one cycle behind the status and mask words
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_q & mask_q);
		end
	end

	// ---------------------------------------------------------------
	// Avalon read path
	// ---------------------------------------------------------------
	logic [31:0] rd_word;

	// Unmapped addresses read a fixed marker instead of hanging the bus
	// Software can probe for the bank by reading an unused index
	always_comb begin
		rd_word = MCC_BUS_ERR_WORD;
		for (int i = 0; i < MCC_NCAL; i++) begin
			if (avm_req_i.address == CAL_IDX[i]) begin
				rd_word = cal_q[i];
			end
		end
		case (avm_req_i.address)
			MCC_IDX_CTRL: rd_word = {30'h0, ctrl_q};
			MCC_IDX_IRQ_STAT: rd_word = {30'h0, stat_q};
			MCC_IDX_IRQ_MASK: rd_word = {30'h0, mask_q};
			MCC_IDX_STATUS: rd_word = {30'h0, cur_present_o, config_checksum_ok_o};
			default: rd_word = rd_word;
		endcase
	end

	// One wait state per access; waitrequest drops for exactly one cycle
	// A request is not taken twice: the pending bit blocks the second look
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_pend_q <= 1'b0;
			avm_waitrequest_o <= 1'b1;
			avm_readdata_o <= 32'h0;
		end else begin
			rd_pend_q <= (avm_req_i.read | avm_req_i.write) & ~rd_pend_q;
			avm_waitrequest_o <= ~((avm_req_i.read | avm_req_i.write) & ~rd_pend_q);
			if (avm_req_i.read && !rd_pend_q) begin
				avm_readdata_o <= rd_word;
			end
		end
	end

	// Coefficient leaves through its own flip-flop for the filter datapath
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bandpass_coef_o <= 32'h0;
		end else begin
			bandpass_coef_o <= cal_q[0]; // RQ6
		end
	end

endmodule
`default_nettype wire

/* src/mcc_pkg.sv */
// Package: register map, reset values, field layouts and carriers for the calibration bank
//
// Contract
// RQ1: Every power gain and offset register is a signed fraction worth its contents over 2^31; the code adds offset words unscaled.
// RQ2: Calibrated power is raw power times one plus the gain term, plus the offset term.
// RQ3: Total and fundamental, active and reactive power each get their own gain and offset word.
// RQ4: With detection on, each current sample's magnitude is compared against the signed threshold.
// RQ5: Current is flagged present only after several consecutive samples exceed the threshold.
// RQ6: Software should load the bandpass coefficient with the recommended constant; it resets to 0.
// RQ7: The checksum word plus 24 configuration words must add to all ones for verification to pass.
// RQ8: Software writes the checksum as all ones minus the sum of the other 24 covered words.
// RQ9: Every calibration register returns to zero on power-on, line or software reset.
// RQ10: The checksum is checked continuously and a mismatch sets a sticky error event.
`default_nettype none
package mcc_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [9:0] MCC_IDX_BANDPASS = 10'h125;
	localparam logic [9:0] MCC_IDX_FA_GAIN = 10'h127;
	localparam logic [9:0] MCC_IDX_FA_OFFS = 10'h128;
	localparam logic [9:0] MCC_IDX_FR_GAIN = 10'h129;
	localparam logic [9:0] MCC_IDX_FR_OFFS = 10'h12a;
	localparam logic [9:0] MCC_IDX_TA_GAIN = 10'h12e;
	localparam logic [9:0] MCC_IDX_TA_OFFS = 10'h12f;
	localparam logic [9:0] MCC_IDX_TR_GAIN = 10'h130;
	localparam logic [9:0] MCC_IDX_TR_OFFS = 10'h131;
	localparam logic [9:0] MCC_IDX_CONFIG_CHECKSUM = 10'h133;
	localparam logic [9:0] MCC_IDX_THRESH = 10'h134;
	localparam logic [9:0] MCC_IDX_CTRL = 10'h140;
	localparam logic [9:0] MCC_IDX_IRQ_STAT = 10'h141;
	localparam logic [9:0] MCC_IDX_IRQ_MASK = 10'h142;
	localparam logic [9:0] MCC_IDX_STATUS = 10'h143;

	// ---------------------------------------------------------------
	// Values, fields and counts
	// ---------------------------------------------------------------
	localparam logic [31:0] MCC_RST_WORD = 32'h0000_0000;
	localparam logic [31:0] MCC_CONFIG_CHECKSUM_GOOD = 32'hffff_ffff;
	localparam logic [31:0] MCC_BUS_ERR_WORD = 32'hdead_beef;
	localparam int MCC_FRAC_BITS = 31;
	localparam int MCC_NCAL = 11;
	// Ten bank words besides the checksum plus these outside words make the 24 covered
	localparam int MCC_NEXT = 14;
	localparam logic [3:0] MCC_DET_RUN = 4'h4;
	localparam int MCC_CTRL_DET_EN = 0;
	localparam int MCC_CTRL_SWRST = 1;
	localparam int MCC_EV_CKERR = 0;
	localparam int MCC_EV_DET = 1;
	localparam int MCC_NEV = 2;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic signed [31:0] total_active;
		logic signed [31:0] total_reactive;
		logic signed [31:0] fund_active;
		logic signed [31:0] fund_reactive;
	} mcc_power_t;

	typedef struct packed {
		logic [9:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} mcc_avm_req_t;

endpackage
`default_nettype wire

/* test/mcc_asserts.sv */
// Checker for bus handshake, power strobe, detection and line reset relations
`default_nettype none
module mcc_asserts
	import mcc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire mcc_avm_req_t avm_req_i,
	input wire logic [31:0] avm_readdata_o,
	input wire logic avm_waitrequest_o,
	input wire logic line_rst_i,
	input wire mcc_power_t cal_power_o,
	input wire logic raw_valid_i,
	input wire logic cur_valid_i,
	input wire logic cal_valid_o,
	input wire logic [31:0] bandpass_coef_o,
	input wire logic cur_present_o
);
	// -----------------------------------------
	// Properties
	// -----------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	a_wait_taken: assert property ((avm_req_i.read || avm_req_i.write) && avm_waitrequest_o
		|=> !avm_waitrequest_o) else $error("access not answered after one wait state");
	a_wait_single: assert property (!avm_waitrequest_o |=> avm_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_wait_cause: assert property (!avm_waitrequest_o
		|-> $past(avm_req_i.read) || $past(avm_req_i.write)) else $error("answer without request");
	a_rdata_stands: assert property ($changed(avm_readdata_o) |-> $past(avm_req_i.read))
		else $error("read data moved without a read");
	a_cal_lag: assert property (raw_valid_i |=> cal_valid_o)
		else $error("calibrated strobe missing");
	a_cal_cause: assert property (cal_valid_o |-> $past(raw_valid_i))
		else $error("calibrated strobe without raw strobe");
	a_cal_hold: assert property (!cal_valid_o |-> $stable(cal_power_o))
		else $error("calibrated power moved without strobe");
	a_present_cause: assert property ($rose(cur_present_o)
		|-> $past(cur_valid_i) || $past(cur_valid_i, 2)) else $error("present without sample");
	a_line_clear: assert property ($rose(line_rst_i)
		|-> ##[1:6] bandpass_coef_o == MCC_RST_WORD) else $error("line reset left coefficient");
	c_access: cover property (!avm_waitrequest_o);
	c_power: cover property (cal_valid_o);
	c_present: cover property ($rose(cur_present_o));
endmodule
bind mcc_top mcc_asserts u_chk (.*);
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the calibration bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import mcc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	mcc_avm_req_t req = '0;
	logic [31:0] ext [MCC_NEXT] = '{default: 32'h01234567};
	logic line_rst = 1'b0;
	mcc_power_t raw = '0;
	mcc_power_t cal;
	logic raw_v = 1'b0;
	logic signed [31:0] cur = '0;
	logic cur_v = 1'b0;
	logic wreq, cal_v, pres, ok, irq;
	logic [31:0] rdata, bp, rd, ex, s;
	int bad_count = 0;
	int checks_done = 0;
	logic [9:0] rows [12] = '{MCC_IDX_BANDPASS, MCC_IDX_FA_GAIN, MCC_IDX_FA_OFFS, MCC_IDX_FR_GAIN,
		MCC_IDX_FR_OFFS, MCC_IDX_TA_GAIN, MCC_IDX_TA_OFFS, MCC_IDX_TR_GAIN, MCC_IDX_TR_OFFS,
		MCC_IDX_CONFIG_CHECKSUM, MCC_IDX_THRESH, 10'h3ff};
	int smp [8] = '{101, -150, 150, 100, -101, 200, -300, -1000};
	mcc_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .avm_req_i(req),
		.avm_readdata_o(rdata), .avm_waitrequest_o(wreq), .ext_cfg_i(ext), .line_rst_i(line_rst),
		.raw_power_i(raw), .raw_valid_i(raw_v), .cur_sample_i(cur), .cur_valid_i(cur_v),
		.cal_power_o(cal), .cal_valid_o(cal_v), .bandpass_coef_o(bp), .cur_present_o(pres),
		.config_checksum_ok_o(ok), .irq_o(irq));
	always #2 clk_sys_i = ~clk_sys_i;
	// -----------------------------------------
	// Helpers
	// -----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// Holds the request until waitrequest is sampled low; bounded wait
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n = 0;
		req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		rd = rdata;
		req <= '0;
		if (n >= 50) begin
			bad_count++;
			end_sim();
		end
		@(posedge clk_sys_i);
	endtask
	// Pattern per register, so a crossed address decode shows up
	function automatic logic [31:0] pat(input logic [9:0] a);
		return 32'h811d2ba7 ^ {a, 22'h0};
	endfunction
	// Fraction over 2^31: P = P' + P'*S + C, wrapping at 32 bits
	function automatic logic [31:0] calp(input logic signed [31:0] p, input logic [9:0] g,
		input logic [9:0] o);
		logic signed [63:0] m;
		m = p * $signed(pat(g));
		return p + m[62:31] + pat(o);
	endfunction
	task automatic samp(input int v);
		cur <= v;
		cur_v <= 1'b1;
		@(posedge clk_sys_i);
		cur_v <= 1'b0;
		tick(2);
	endtask
	// -----------------------------------------
	// Main sequence
	// -----------------------------------------
	initial begin
		tick(6);
		arst_n_i <= 1'b1;
		tick(1);
		for (int i = 0; i < 12; i++) begin
			ex = (i == 11) ? MCC_BUS_ERR_WORD : MCC_RST_WORD;
			bus(1'b0, rows[i], '0);
			cmp("reset value", ex, rd);
			bus(1'b1, rows[i], pat(rows[i]));
			bus(1'b0, rows[i], '0);
			cmp("readback", (i == 11) ? ex : pat(rows[i]), rd);
		end
		cmp("bandpass out", pat(MCC_IDX_BANDPASS), bp);
		$display("register rows done");
		raw <= {32'h000f4240, 32'hffe17b80, 32'h7fffffff, 32'hfffffff9};
		raw_v <= 1'b1;
		tick(1);
		raw_v <= 1'b0;
		// Look at mid-cycle, while the one-cycle strobe stands
		@(negedge clk_sys_i);
		cmp("cal valid", {31'h0, cal_v}, 32'h1);
		cmp("ta", calp(raw.total_active, MCC_IDX_TA_GAIN, MCC_IDX_TA_OFFS), cal.total_active);
		cmp("tr", calp(raw.total_reactive, MCC_IDX_TR_GAIN, MCC_IDX_TR_OFFS), cal.total_reactive);
		cmp("fa", calp(raw.fund_active, MCC_IDX_FA_GAIN, MCC_IDX_FA_OFFS), cal.fund_active);
		cmp("fr", calp(raw.fund_reactive, MCC_IDX_FR_GAIN, MCC_IDX_FR_OFFS), cal.fund_reactive);
		@(posedge clk_sys_i);
		$display("power done");
		// Equal to threshold is not above it, so it breaks the run
		bus(1'b1, MCC_IDX_THRESH, 32'h64);
		bus(1'b1, MCC_IDX_CTRL, 32'h1);
		foreach (smp[i]) begin
			samp(smp[i]);
			cmp("present", {31'h0, pres}, {31'h0, i == 7});
		end
		$display("detect done");
		line_rst <= 1'b1;
		tick(2);
		line_rst <= 1'b0;
		tick(6);
		for (int i = 0; i < 11; i++) begin
			bus(1'b0, rows[i], '0);
			cmp("line reset", MCC_RST_WORD, rd);
		end
		s = '0;
		foreach (ext[i]) s = s + ext[i];
		cmp("sum wrong", {31'h0, ok}, 32'h0);
		cmp("covered words", 32'h18, 32'(MCC_NEXT + MCC_NCAL - 1));
		bus(1'b1, MCC_IDX_CONFIG_CHECKSUM, MCC_CONFIG_CHECKSUM_GOOD - s);
		tick(3);
		cmp("sum good", {31'h0, ok}, 32'h1);
		bus(1'b1, MCC_IDX_IRQ_STAT, 32'h3);
		bus(1'b1, MCC_IDX_IRQ_MASK, 32'h1);
		bus(1'b0, MCC_IDX_IRQ_STAT, '0);
		cmp("status clear", 32'h0, rd);
		cmp("irq idle", {31'h0, irq}, 32'h0);
		ext[0] <= ext[0] + 32'h1;
		tick(3);
		bus(1'b0, MCC_IDX_IRQ_STAT, '0);
		cmp("status set", 32'h1, rd);
		cmp("irq high", {31'h0, irq}, 32'h1);
		bus(1'b1, MCC_IDX_IRQ_MASK, 32'h0);
		tick(2);
		cmp("irq masked", {31'h0, irq}, 32'h0);
		$display("checksum done");
		bus(1'b1, MCC_IDX_CTRL, 32'h2);
		tick(2);
		bus(1'b0, MCC_IDX_CONFIG_CHECKSUM, '0);
		cmp("soft reset", MCC_RST_WORD, rd);
		$display("soft reset done");
		end_sim();
	end
endmodule
`default_nettype wire
